// File: tmc_timer.sv
/*
 dual timer/counter with external interrupt flags, reached through
 the special-register port (addr, wr_en, wr_data, rd_data).
 assumes the interrupt controller pulses isr_ack lines on entry.
*/
`timescale 1ns/1ps
`include "tmc_params.svh"
module tmc_timer
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// special register port
	input  wire logic [7:0] addr,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	// clock divider selects
	input  wire logic       t0_clock_div_select,
	input  wire logic       t1_clock_div_select,
	// service entry acknowledges
	input  wire logic       t0_isr_ack,
	input  wire logic       t1_isr_ack,
	input  wire logic       ext0_isr_ack,
	input  wire logic       ext1_isr_ack,
	// pins
	input  wire logic       ext_irq0_pin_n,
	input  wire logic       ext_irq1_pin_n,
	input  wire logic       t0_count_pin,
	input  wire logic       t1_count_pin,
	// flag outputs
	output logic            t0_overflow_flag,
	output logic            t1_overflow_flag,
	output logic            ext_irq0_flag,
	output logic            ext_irq1_flag
);
	////////////////////////////////////////////////////////////////////////
	logic [3:0] s1_q, s2_q, prev_q;
	logic [7:0] ctrl_q, ctrl_d, mode_q, mode_d;
	logic [7:0] t0l_q, t0l_d, t0h_q, t0h_d, t1l_q, t1l_d, t1h_q, t1h_d;
	logic       tick0, tick1;
	logic [3:0] fall;
	logic       t0_en, t1_en, t0_inc, t1_inc, th0_inc;
	logic       ovf0, ovf1;

	// pin synchronisers: irq0, irq1, cnt0, cnt1
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 4'hf;
			s2_q <= 4'hf;
			prev_q <= 4'hf;
		end else begin
			s1_q <= {t1_count_pin, t0_count_pin,
				ext_irq1_pin_n, ext_irq0_pin_n};
			s2_q <= s1_q;
			prev_q <= s2_q;
		end
	end

	assign fall = prev_q & ~s2_q;

	// internal tick dividers
	tmc_tick_div u_div0 (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.fast_sel (t0_clock_div_select),
		.tick     (tick0)
	);
	tmc_tick_div u_div1 (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.fast_sel (t1_clock_div_select),
		.tick     (tick1)
	);

	// field decode of one timer's nibble of the mode register
	function automatic logic [3:0] fld(input logic [7:0] m, input logic t1);
		fld = t1 ? m[`TMC_T1_FIELD +: 4] : m[3:0];
	endfunction

	function automatic logic gate_ok(input logic [3:0] f, input logic run,
		input logic pin);
		gate_ok = run && (!f[`TMC_M_GATE] || pin);
	endfunction

	function automatic logic src(input logic [3:0] f, input logic tk,
		input logic fe);
		src = f[`TMC_M_CT] ? fe : tk;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// enables and count sources
	always_comb begin
		t0_en = gate_ok(fld(mode_q, 1'b0), ctrl_q[`TMC_B_TR0],
			s2_q[0]);
		t1_en = gate_ok(fld(mode_q, 1'b1), ctrl_q[`TMC_B_TR1],
			s2_q[1]);
		t0_inc = t0_en && src(fld(mode_q, 1'b0), tick0, fall[2]);
		t1_inc = t1_en && src(fld(mode_q, 1'b1), tick1, fall[3]) &&
			(tmc_mode_e'(mode_q[5:4]) != TMC_MODE_SPLIT);
		th0_inc = ctrl_q[`TMC_B_TR1] && tick0;
	end

	// counter next state; timer 0 low/high and timer 1
	always_comb begin
		t0l_d = t0l_q;
		t0h_d = t0h_q;
		t1l_d = t1l_q;
		t1h_d = t1h_q;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		unique case (tmc_mode_e'(mode_q[1:0]))
			TMC_MODE_PRE13: if (t0_inc) begin
				t0l_d = {3'h0, t0l_q[`TMC_PRE_MSB:0] + 5'h01};
				if (t0l_q[`TMC_PRE_MSB:0] == 5'h1f) begin
					t0h_d = t0h_q + 8'h01;
					ovf0 = (t0h_q == 8'hff);
				end
			end
			TMC_MODE_FULL16: if (t0_inc) begin
				{t0h_d, t0l_d} = {t0h_q, t0l_q} + 16'h0001;
				ovf0 = ({t0h_q, t0l_q} == 16'hffff);
			end
			TMC_MODE_RELOAD8: if (t0_inc) begin
				ovf0 = (t0l_q == 8'hff);
				t0l_d = ovf0 ? t0h_q : t0l_q + 8'h01;
			end
			TMC_MODE_SPLIT: begin
				if (t0_inc) begin
					t0l_d = t0l_q + 8'h01;
					ovf0 = (t0l_q == 8'hff);
				end
				if (th0_inc) begin
					t0h_d = t0h_q + 8'h01;
					ovf1 = (t0h_q == 8'hff);
				end
			end
		endcase
		unique case (tmc_mode_e'(mode_q[5:4]))
			TMC_MODE_PRE13: if (t1_inc) begin
				t1l_d = {3'h0, t1l_q[`TMC_PRE_MSB:0] + 5'h01};
				if (t1l_q[`TMC_PRE_MSB:0] == 5'h1f) begin
					t1h_d = t1h_q + 8'h01;
					ovf1 = ovf1 || (t1h_q == 8'hff);
				end
			end
			TMC_MODE_FULL16: if (t1_inc) begin
				{t1h_d, t1l_d} = {t1h_q, t1l_q} + 16'h0001;
				ovf1 = ovf1 || ({t1h_q, t1l_q} == 16'hffff);
			end
			TMC_MODE_RELOAD8: if (t1_inc) begin
				ovf1 = ovf1 || (t1l_q == 8'hff);
				t1l_d = (t1l_q == 8'hff) ? t1h_q : t1l_q + 8'h01;
			end
			TMC_MODE_SPLIT: begin
				t1l_d = t1l_q;
			end
		endcase
		// software writes win over counting
		if (wr_en && addr == `TMC_ADDR_T0L) t0l_d = wr_data;
		if (wr_en && addr == `TMC_ADDR_T0H) t0h_d = wr_data;
		if (wr_en && addr == `TMC_ADDR_T1L) t1l_d = wr_data;
		if (wr_en && addr == `TMC_ADDR_T1H) t1h_d = wr_data;
	end

	////////////////////////////////////////////////////////////////////////
	// control and mode registers; hardware set beats any clear
	always_comb begin
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		if (wr_en && addr == `TMC_ADDR_MODE) mode_d = wr_data;
		if (wr_en && addr == `TMC_ADDR_CTRL) ctrl_d = wr_data;
		if (t1_isr_ack) ctrl_d[`TMC_B_TF1] = 1'b0;
		if (t0_isr_ack) ctrl_d[`TMC_B_TF0] = 1'b0;
		if (ovf1) ctrl_d[`TMC_B_TF1] = 1'b1;
		if (ovf0) ctrl_d[`TMC_B_TF0] = 1'b1;
		// external irq 1 and 0: type one is falling edge, zero is low level
		if (ctrl_q[`TMC_B_IT1]) begin
			if (ext1_isr_ack) ctrl_d[`TMC_B_IE1] = 1'b0;
			if (fall[1]) ctrl_d[`TMC_B_IE1] = 1'b1;
		end else begin
			ctrl_d[`TMC_B_IE1] = !s2_q[1];
		end
		if (ctrl_q[`TMC_B_IT0]) begin
			if (ext0_isr_ack) ctrl_d[`TMC_B_IE0] = 1'b0;
			if (fall[0]) ctrl_d[`TMC_B_IE0] = 1'b1;
		end else begin
			ctrl_d[`TMC_B_IE0] = !s2_q[0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `TMC_RST_BYTE;
			mode_q <= `TMC_RST_BYTE;
			t0l_q <= `TMC_RST_BYTE;
			t0h_q <= `TMC_RST_BYTE;
			t1l_q <= `TMC_RST_BYTE;
			t1h_q <= `TMC_RST_BYTE;
		end else begin
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
			t0l_q <= t0l_d;
			t0h_q <= t0h_d;
			t1l_q <= t1l_d;
			t1h_q <= t1h_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read high
	always_comb begin
		unique case (addr)
			`TMC_ADDR_CTRL: rd_data = ctrl_q;
			`TMC_ADDR_MODE: rd_data = mode_q;
			`TMC_ADDR_T0L:  rd_data = t0l_q;
			`TMC_ADDR_T1L:  rd_data = t1l_q;
			`TMC_ADDR_T0H:  rd_data = t0h_q;
			`TMC_ADDR_T1H:  rd_data = t1h_q;
			default:        rd_data = `TMC_RD_UNMAP;
		endcase
	end

	assign t0_overflow_flag = ctrl_q[`TMC_B_TF0];
	assign t1_overflow_flag = ctrl_q[`TMC_B_TF1];
	assign ext_irq0_flag = ctrl_q[`TMC_B_IE0];
	assign ext_irq1_flag = ctrl_q[`TMC_B_IE1];
endmodule

// File: tmc_params.svh
/*
 timer/counter block constants: register addresses, bit positions,
 divider ratios. assumes inclusion by the timer and tick divider modules.
*/
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
`define TMC_ADDR_CTRL   8'h88
`define TMC_ADDR_MODE   8'h89
`define TMC_ADDR_T0L    8'h8a
`define TMC_ADDR_T1L    8'h8b
`define TMC_ADDR_T0H    8'h8c
`define TMC_ADDR_T1H    8'h8d
`define TMC_B_TF1       7
`define TMC_B_TR1       6
`define TMC_B_TF0       5
`define TMC_B_TR0       4
`define TMC_B_IE1       3
`define TMC_B_IT1       2
`define TMC_B_IE0       1
`define TMC_B_IT0       0
`define TMC_M_GATE      3
`define TMC_M_CT        2
`define TMC_M_HI        1
`define TMC_M_LO        0
`define TMC_T1_FIELD    4
`define TMC_DIV_FAST    4'h3
`define TMC_DIV_SLOW    4'hb
`define TMC_PRE_MSB     4
`define TMC_RST_BYTE    8'h00
`define TMC_RD_UNMAP    8'hff
`endif

// File: tmc_pkg.sv
/*
 types shared by the timer/counter block.
 assumes tmc_params.svh is on the include path.
*/
package tmc_pkg;
	typedef enum logic [1:0] {
		TMC_MODE_PRE13 = 2'b00,
		TMC_MODE_FULL16 = 2'b01,
		TMC_MODE_RELOAD8 = 2'b10,
		TMC_MODE_SPLIT = 2'b11
	} tmc_mode_e;
endpackage

// File: tmc_tick_div.sv
/*
 internal count tick generator: one-cycle pulse every 4 or 12 clocks.
 assumes the select input is synchronous to mclk.
*/
`timescale 1ns/1ps
`include "tmc_params.svh"
module tmc_tick_div
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// control
	input  wire logic fast_sel,
	// tick
	output logic      tick
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] top;

	// count down to zero then reload with the selected ratio
	always_comb begin
		top = fast_sel ? `TMC_DIV_FAST : `TMC_DIV_SLOW;
		tick = (cnt_q == 4'h0);
		if (tick || cnt_q > top) begin
			cnt_d = top;
		end else begin
			cnt_d = cnt_q - 4'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// File: tmc_timer_sva.sv
/*
 port checker for the timer/counter block.
 assumes binding to tmc_timer and a free-running mclk.
*/
`timescale 1ns/1ps
module tmc_timer_sva
	import tmc_pkg::*;
(
	// clock, reset and register port
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic [7:0] addr,
	input wire logic       wr_en,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	// service ack and pins
	input wire logic       ext1_isr_ack,
	input wire logic       ext_irq0_pin_n,
	input wire logic       ext_irq1_pin_n,
	// flags
	input wire logic       t0_overflow_flag,
	input wire logic       t1_overflow_flag,
	input wire logic       ext_irq0_flag,
	input wire logic       ext_irq1_flag
);
logic [7:0] ctl_q, ctl_d, mod_q, mod_d;
////////////////////////////////////////////////////////////////////////
// shadow of software writes to control and mode
always_comb begin
	ctl_d = ctl_q;
	mod_d = mod_q;
	if (wr_en && addr == 8'h88) ctl_d = wr_data;
	if (wr_en && addr == 8'h89) mod_d = wr_data;
end
always_ff @(posedge mclk or negedge rst_n) begin
	if (!rst_n) ctl_q <= 8'h00;
	else ctl_q <= ctl_d;
	if (!rst_n) mod_q <= 8'h00;
	else mod_q <= mod_d;
end
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////
// assertions
AST_FLAGS_READ:
	assert property (addr == 8'h88 |-> rd_data[7] == t1_overflow_flag &&
		rd_data[5] == t0_overflow_flag && rd_data[3] == ext_irq1_flag &&
		rd_data[1] == ext_irq0_flag) else $error("flag bits differ");
AST_TF0_SW_SET:
	assert property (wr_en && addr == 8'h88 && wr_data[5] |=>
		t0_overflow_flag) else $error("t0 flag not set by write");
AST_TF1_SW_SET:
	assert property (wr_en && addr == 8'h88 && wr_data[7] |=>
		t1_overflow_flag) else $error("t1 flag not set by write");
AST_T0_STOPPED:
	assert property (!$past(ctl_q[4]) && !$past(wr_en) && addr == 8'h8a &&
		$past(addr) == 8'h8a |-> $stable(rd_data))
		else $error("timer 0 counted while off");
AST_T1_MODE3:
	assert property ($past(mod_q[5:4]) == 2'b11 && !$past(wr_en) &&
		addr == 8'h8b && $past(addr) == 8'h8b |-> $stable(rd_data))
		else $error("timer 1 counted in mode 3");
AST_LEVEL0:
	assert property ((!ext_irq0_pin_n && !ctl_q[0])[*4] |-> ext_irq0_flag)
		else $error("level flag not following pin");
AST_EDGE1_SET:
	assert property ($fell(ext_irq1_pin_n) && ctl_q[2] ##1
		(!ext1_isr_ack && !ext_irq1_pin_n && !wr_en)[*3] |-> ext_irq1_flag)
		else $error("edge flag not set");
AST_EDGE1_ACK:
	assert property (ctl_q[2] && ext1_isr_ack && !wr_en && ext_irq1_pin_n &&
		$past(ext_irq1_pin_n) && $past(ext_irq1_pin_n, 2) |=>
		!ext_irq1_flag) else $error("edge flag not cleared by ack");
endmodule
bind tmc_timer tmc_timer_sva u_sva (.*);

// File: tmc_pin_model.sv
/*
 pin-side model: irq pins and counter inputs, idle high.
 assumes tasks are called from the bench between clock edges.
*/
`timescale 1ns/1ps
module tmc_pin_model
	import tmc_pkg::*;
(
	// clock
	input  wire logic       mclk,
	// pins
	output logic      [1:0] irq_n = 2'b11,
	output logic      [1:0] cnt   = 2'b11
);
////////////////////////////////////////////////////////////////////////
// irq pin level, high means released
task automatic irq(input int ch, input logic v);
	@(posedge mclk);
	irq_n[ch] <= v;
endtask
// n falling edges, each two cycles low, then high three cycles (two after the last)
task automatic edges(input int ch, input int n);
	repeat (n) begin
		@(posedge mclk);
		cnt[ch] <= 1'b0;
		repeat (2) @(posedge mclk);
		cnt[ch] <= 1'b1;
		repeat (2) @(posedge mclk);
	end
endtask
endmodule

// File: tmc_timer_bench.sv
/*
 self-checking bench for tmc_timer.
 assumes the pin model and checker files are compiled first.
*/
`timescale 1ns/1ps
module tmc_timer_bench
	import tmc_pkg::*;
;
logic       mclk = 1'b0, rst_n = 1'b0, wr_en = 1'b0;
logic       sel0 = 1'b0, ack0 = 1'b0, ack3 = 1'b0;
logic       ack1 = 1'b0, ack2 = 1'b0;
wire  [3:0] fl;
logic [7:0] addr = 8'h00, wr_data = 8'h00;
wire  [7:0] rd_data;
wire  [1:0] pn, cn;
int         failures = 0, num_checks = 0;
always #20 mclk = ~mclk;
tmc_pin_model pm (.mclk(mclk), .irq_n(pn), .cnt(cn));
tmc_timer dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
	.wr_data(wr_data), .rd_data(rd_data), .t0_clock_div_select(sel0),
	.t1_clock_div_select(1'b0), .t0_isr_ack(ack0), .t1_isr_ack(ack1),
	.ext0_isr_ack(ack2), .ext1_isr_ack(ack3), .ext_irq0_pin_n(pn[0]),
	.ext_irq1_pin_n(pn[1]), .t0_count_pin(cn[0]), .t1_count_pin(cn[1]),
	.t0_overflow_flag(fl[2]), .t1_overflow_flag(fl[3]),
	.ext_irq0_flag(fl[0]), .ext_irq1_flag(fl[1]));
////////////////////////////////////////////////////////////////////////
// register access and compare
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge mclk);
	addr <= a;
	wr_data <= d;
	wr_en <= 1'b1;
	@(posedge mclk);
	wr_en <= 1'b0;
endtask
task automatic chk(input logic [7:0] a, input logic [7:0] e);
	@(posedge mclk);
	addr <= a;
	@(negedge mclk);
	num_checks++;
	if (rd_data !== e) begin
		failures++;
		$display("ERROR reg %h expected %h seen %h", a, e, rd_data);
	end
endtask
// flag pins {t1 ovf, t0 ovf, irq1, irq0}, sampled where chk left off
task automatic chk_fl(input logic [3:0] e);
	num_checks++;
	if (fl !== e) begin
		failures++;
		$display("ERROR flags expected %h seen %h", e, fl);
	end
endtask
task automatic stop_test();
	$display("checks %0d failures %0d", num_checks, failures);
	if (failures == 0 && num_checks > 0) $display("Test passed");
	else $display("Test failed");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////
// test sequence
initial begin
	repeat (3) @(posedge mclk);
	rst_n <= 1'b1;
	wr(8'h8e, 8'h55);
	for (int i = 8'h88; i < 8'h8e; i++) chk(i[7:0], 8'h00);
	chk(8'h8e, 8'hff);
	wr(8'h88, 8'ha0);
	chk(8'h88, 8'ha0);
	@(posedge mclk) sel0 <= 1'b1;
	wr(8'h89, 8'h01);
	wr(8'h8a, 8'hfe);
	wr(8'h8c, 8'hff);
	wr(8'h88, 8'h10);
	repeat (12) @(posedge mclk);
	chk(8'h88, 8'h30);
	@(posedge mclk) ack0 <= 1'b1;
	@(posedge mclk) ack0 <= 1'b0;
	chk(8'h88, 8'h10);
	wr(8'h89, 8'h04);
	wr(8'h8a, 8'h1f);
	wr(8'h8c, 8'h00);
	pm.edges(0, 1);
	repeat (4) @(posedge mclk);
	chk(8'h8a, 8'h00);
	chk(8'h8c, 8'h01);
	wr(8'h89, 8'h0d);
	pm.irq(0, 1'b0);
	pm.edges(0, 2);
	repeat (4) @(posedge mclk);
	chk(8'h8a, 8'h00);
	chk(8'h88, 8'h12);
	pm.irq(0, 1'b1);
	repeat (4) @(posedge mclk);
	pm.edges(0, 2);
	repeat (4) @(posedge mclk);
	chk(8'h8a, 8'h02);
	wr(8'h88, 8'h00);
	chk(8'h8a, 8'h02);
	pm.edges(0, 2);
	repeat (4) @(posedge mclk);
	chk(8'h8a, 8'h02);
	wr(8'h89, 8'h60);
	wr(8'h8d, 8'hfe);
	wr(8'h8b, 8'hff);
	wr(8'h88, 8'h40);
	pm.edges(1, 3);
	repeat (4) @(posedge mclk);
	chk(8'h8b, 8'hfe);
	chk(8'h88, 8'hc0);
	chk_fl(4'h8);
	@(posedge mclk) ack1 <= 1'b1;
	@(posedge mclk) ack1 <= 1'b0;
	chk(8'h88, 8'h40);
	wr(8'h89, 8'h70);
	chk(8'h8b, 8'hfe);
	pm.edges(1, 2);
	repeat (4) @(posedge mclk);
	chk(8'h8b, 8'hfe);
	wr(8'h88, 8'h04);
	pm.irq(1, 1'b0);
	repeat (4) @(posedge mclk);
	chk(8'h88, 8'h0c);
	chk_fl(4'h2);
	pm.irq(1, 1'b1);
	repeat (2) @(posedge mclk);
	@(posedge mclk) ack3 <= 1'b1;
	@(posedge mclk) ack3 <= 1'b0;
	chk(8'h88, 8'h04);
	wr(8'h88, 8'h05);
	pm.irq(0, 1'b0);
	repeat (4) @(posedge mclk);
	chk(8'h88, 8'h07);
	chk_fl(4'h1);
	pm.irq(0, 1'b1);
	repeat (2) @(posedge mclk);
	@(posedge mclk) ack2 <= 1'b1;
	@(posedge mclk) ack2 <= 1'b0;
	chk(8'h88, 8'h05);
	stop_test();
end
// watchdog: the sequence needs well under 1000 cycles
initial begin
	#100000;
	failures++;
	stop_test();
end
endmodule
